// *** smt_pkg.sv ***
// Shared constants, register map and field layouts of the 16-bit mode timer
package smt_pkg;

  // ****************************************************************
  // Register byte offsets on the AXI4-Lite slave
  // ****************************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;   // Control word
  localparam logic [4:0] OFF_COUNT = 5'h04;  // Live count
  localparam logic [4:0] OFF_RELOAD = 5'h08; // Reload / compare value
  localparam logic [4:0] OFF_STATUS = 5'h0c; // Sticky events, write 1 clears
  localparam logic [4:0] OFF_MASK = 5'h10;   // Interrupt enables

  // ****************************************************************
  // Counting modes, held in the control word
  // ****************************************************************
  localparam logic [1:0] MODE_ONESHOT = 2'h0; // Free start, single run
  localparam logic [1:0] MODE_TRIG = 2'h1;    // Run after pin edge
  localparam logic [1:0] MODE_COMPARE = 2'h2; // Match and keep going
  localparam logic [1:0] MODE_GATED = 2'h3;   // Count while pin active

  // Gated-mode interrupt source select (interrupt_config_field)
  localparam logic [1:0] ICFG_GATE = 2'h1;   // Gate deassertion only
  localparam logic [1:0] ICFG_RELOAD = 2'h2; // Reload only

  // ****************************************************************
  // Control word layout, bit 0 first from the right
  // ****************************************************************
  typedef struct packed {
    logic out_en;       // Bit 9: timer output alternate function on
    logic [1:0] icfg;   // Bits 8:7: interrupt_config_field
    logic [2:0] presc;  // Bits 6:4: prescale, divide by 2**presc
    logic [1:0] mode;   // Bits 3:2: counting mode
    logic pol;          // Bit 1: input_output_polarity
    logic en;           // Bit 0: timer enable
  } smt_ctrl_t;

  localparam int CTRL_W = 10;                  // Width of control word
  localparam logic [9:0] CTRL_RST = 10'h000;   // Control after reset
  localparam logic [15:0] COUNT_RST = 16'h0000; // Count after reset
  localparam logic [15:0] RELOAD_RST = 16'hffff; // Reload after reset
  localparam logic [15:0] COUNT_ONE = 16'h0001;  // Restart value

  // ****************************************************************
  // Status and mask bit positions
  // ****************************************************************
  localparam int STS_W = 3;       // Number of event bits
  localparam int STS_RELOAD = 0;  // Reload / time-out reached
  localparam int STS_COMPARE = 1; // Compare match
  localparam int STS_GATE = 2;    // Gate input deasserted
  localparam logic [2:0] STS_RST = 3'h0; // Status and mask after reset

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** smt_prescale.sv ***
// Prescaler that turns the system clock into timer clock ticks
`timescale 1ns/1ns
module smt_prescale #(
  parameter int PW = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [PW-1:0] presc,
  output logic tick
);
  localparam int CW = (1 << PW) - 1; // Enough bits for divide by 2**(2**PW-1)

  logic [CW-1:0] cnt_reg; // Cycles since last tick
  logic [CW-1:0] limit;   // Terminal value for the chosen ratio

  // ****************************************************************
  // Divider
  // ****************************************************************
  assign limit = CW'((1 << presc) - 1);
  assign tick = run && (cnt_reg == limit);

  // Held at zero while stopped, so every run starts a full period
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run || tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// *** smt_input.sv ***
// Timer input pin conditioner: active level and edge pulses
`timescale 1ns/1ns
module smt_input (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  input wire logic pol,
  output logic active,
  output logic rise,
  output logic fall
);
  logic prev_reg; // Active level one cycle ago

  // ****************************************************************
  // Level and edges relative to the polarity bit
  // ****************************************************************
  // Polarity 1 means high is active and the rising pin edge triggers
  assign active = ~(pin ^ pol);
  assign rise = active && !prev_reg;
  assign fall = !active && prev_reg;

  // Remember the last level for edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Pin low and polarity 0 after reset read as active: no false edge
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= active;
    end
  end
endmodule

// *** smt_timer.sv ***
// 16-bit mode timer with AXI4-Lite registers and one interrupt
`timescale 1ns/1ns
module smt_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic irq
);
  import smt_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Full-word address match, upper bits must be zero
  function automatic logic hit(input logic [31:0] a, input logic [4:0] o);
    hit = (a[31:5] == 27'h0) && (a[4:0] == o);
  endfunction

  // Merge new data into an old word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old_w & ~m) | (new_w & m);
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // Disabled
    ST_WAIT = 3'b010, // Armed, waiting for trigger edge
    ST_RUN = 3'b100   // Counting
  } smt_state_t;

  // Bus side state
  logic aw_have_reg, w_have_reg; // Address or data held
  logic [31:0] awaddr_reg, wdata_reg; // Held write request
  logic [3:0] wstrb_reg; // Held byte strobes
  logic awready_reg, wready_reg, arready_reg; // Ready flops
  logic bvalid_reg, rvalid_reg; // Response valid flops
  logic [1:0] bresp_reg, rresp_reg; // Response codes
  logic [31:0] rdata_reg; // Read data flop

  // Timer state
  smt_ctrl_t ctrl_reg, ctrl_next; // Control word
  logic [15:0] cnt_reg, cnt_next; // Live count
  logic [15:0] reload_reg; // Reload or compare value
  logic [STS_W-1:0] sts_reg, sts_next, sts_set, sts_clr; // Events
  logic [STS_W-1:0] mask_reg, mask_next; // Interrupt enables
  smt_state_t state_reg, state_next; // Sequencer
  logic tout_reg; // Timer output pin level
  logic irq_reg; // Interrupt flop

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic aw_hs, w_hs, do_write, b_done, ar_hs, r_done;
  logic aw_have_next, w_have_next, bvalid_next, rvalid_next;
  logic wr_ctrl, wr_count, wr_reload, wr_status, wr_mask, wr_ok;
  logic [31:0] wmerged;

  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  // Both halves present and no answer pending: commit the write
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign b_done = bvalid_reg && s_axi_bready;
  assign aw_have_next = aw_hs ? 1'b1 : (do_write ? 1'b0 : aw_have_reg);
  assign w_have_next = w_hs ? 1'b1 : (do_write ? 1'b0 : w_have_reg);
  assign bvalid_next = do_write ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);

  // Register select for the committed write
  assign wr_ctrl = do_write && hit(awaddr_reg, OFF_CTRL);
  assign wr_count = do_write && hit(awaddr_reg, OFF_COUNT);
  assign wr_reload = do_write && hit(awaddr_reg, OFF_RELOAD);
  assign wr_status = do_write && hit(awaddr_reg, OFF_STATUS);
  assign wr_mask = do_write && hit(awaddr_reg, OFF_MASK);
  assign wr_ok = wr_ctrl | wr_count | wr_reload | wr_status | wr_mask;

  // Captures and response; ready returns only after the answer is taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg <= !w_have_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic [31:0] rd_mux;
  logic rd_ok;

  assign ar_hs = s_axi_arvalid && arready_reg;
  assign r_done = rvalid_reg && s_axi_rready;
  assign rvalid_next = ar_hs ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);
  assign rd_ok = hit(s_axi_araddr, OFF_CTRL) | hit(s_axi_araddr, OFF_COUNT)
    | hit(s_axi_araddr, OFF_RELOAD) | hit(s_axi_araddr, OFF_STATUS)
    | hit(s_axi_araddr, OFF_MASK);
  // Unused upper bits and unmapped addresses read as zero
  assign rd_mux =
    hit(s_axi_araddr, OFF_CTRL) ? {22'h0, ctrl_reg} :
    hit(s_axi_araddr, OFF_COUNT) ? {16'h0, cnt_reg} :
    hit(s_axi_araddr, OFF_RELOAD) ? {16'h0, reload_reg} :
    hit(s_axi_araddr, OFF_STATUS) ? {29'h0, sts_reg} :
    hit(s_axi_araddr, OFF_MASK) ? {29'h0, mask_reg} : 32'h0;

  // Data sampled at the address handshake, held until taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_hs) begin
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Timer clock and input pin
  // ****************************************************************
  logic tick, gate_act, trig_rise, gate_fall, run, evt;
  logic is_one, is_trig, is_cmp, is_gated;

  assign is_one = ctrl_reg.mode == MODE_ONESHOT;
  assign is_trig = ctrl_reg.mode == MODE_TRIG;
  assign is_cmp = ctrl_reg.mode == MODE_COMPARE;
  assign is_gated = ctrl_reg.mode == MODE_GATED;
  // Prescaler runs only in RUN; gated mode also needs the pin active
  assign run = (state_reg == ST_RUN) && (!is_gated || gate_act);
  // Count equals reload on a timer clock tick
  assign evt = tick && (cnt_reg == reload_reg);

  smt_prescale #(
    .PW(3)
  ) u_presc (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .presc(ctrl_reg.presc),
    .tick(tick)
  );

  smt_input u_in (
    .mclk(mclk),
    .rst(rst),
    .pin(timer_in),
    .pol(ctrl_reg.pol),
    .active(gate_act),
    .rise(trig_rise),
    .fall(gate_fall)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic hw_stop; // One-shot end clears enable

  assign hw_stop = (state_reg == ST_RUN) && is_one && evt;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (ctrl_reg.en) begin
          // Triggered mode arms and waits; others start at once
          state_next = is_trig ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (!ctrl_reg.en) begin
          state_next = ST_IDLE;
        end else if (trig_rise) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctrl_reg.en || hw_stop) begin
          state_next = ST_IDLE;
        end else if (is_trig && evt) begin
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Counter, control and events
  // ****************************************************************
  // Software write wins over the hardware enable clear
  assign ctrl_next = wr_ctrl ?
    smt_ctrl_t'(CTRL_W'(merge({22'h0, ctrl_reg}, wdata_reg, wstrb_reg))) :
    (hw_stop ? smt_ctrl_t'({ctrl_reg[CTRL_W-1:1], 1'b0}) : ctrl_reg);

  // Only the prescaled tick advances the count, never the pin
  always_comb begin
    cnt_next = cnt_reg;
    if (wr_count) begin
      cnt_next = 16'(merge({16'h0, cnt_reg}, wdata_reg, wstrb_reg));
    end else if (tick) begin
      if (evt && !is_cmp) begin
        cnt_next = COUNT_ONE;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  // Event sources
  assign sts_set[STS_RELOAD] = evt && !is_cmp
    && !(is_gated && ctrl_reg.icfg == ICFG_GATE);
  assign sts_set[STS_COMPARE] = evt && is_cmp;
  assign sts_set[STS_GATE] = (state_reg == ST_RUN) && is_gated
    && gate_fall && (ctrl_reg.icfg != ICFG_RELOAD);
  assign sts_clr = wr_status ?
    (wdata_reg[STS_W-1:0] & {STS_W{wstrb_reg[0]}}) : STS_RST;
  // A new event beats a clear in the same cycle
  assign sts_next = (sts_reg & ~sts_clr) | sts_set;
  assign mask_next = wr_mask ?
    STS_W'(merge({29'h0, mask_reg}, wdata_reg, wstrb_reg)) : mask_reg;

  // Timer register bank
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= smt_ctrl_t'(CTRL_RST);
      cnt_reg <= COUNT_RST;
      reload_reg <= RELOAD_RST;
      sts_reg <= STS_RST;
      mask_reg <= STS_RST;
      state_reg <= ST_IDLE;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      if (wr_reload) begin
        reload_reg <= 16'(merge({16'h0, reload_reg}, wdata_reg,
          wstrb_reg));
      end
      sts_reg <= sts_next;
      mask_reg <= mask_next;
      state_reg <= state_next;
      irq_reg <= |(sts_next & mask_next);
    end
  end

  // Output level: polarity while stopped, toggles at each end or match except in gated mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tout_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      tout_reg <= ctrl_reg.pol;
    end else if (evt && !is_gated) begin
      tout_reg <= !tout_reg;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_out = tout_reg;
  assign timer_out_en = ctrl_reg.out_en;
  assign irq = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_cmp_match;
    state_reg == ST_RUN && is_cmp && evt && !do_write;
  endsequence
  sequence s_end_quiet;
    state_reg == ST_RUN && evt && !do_write;
  endsequence

  oneshot_stop_a: assert property ((s_end_quiet and is_one) |=>
    state_reg == ST_IDLE && !ctrl_reg.en && cnt_reg == 16'h0001)
    else $error("one-shot did not stop at reload");
  trig_rearm_a: assert property ((s_end_quiet and is_trig) |=>
    state_reg == ST_WAIT && cnt_reg == 16'h0001)
    else $error("triggered run did not rearm");
  trig_wait_a: assert property (state_reg == ST_WAIT && ctrl_reg.en
    && !trig_rise && !do_write |=> state_reg == ST_WAIT && $stable(cnt_reg))
    else $error("count moved without trigger");
  cmp_no_restart_a: assert property (s_cmp_match |=>
    cnt_reg == 16'($past(cnt_reg) + 16'h0001) && sts_reg[STS_COMPARE])
    else $error("compare match restarted count");
  cmp_toggle_a: assert property (s_cmp_match |=>
    tout_reg != $past(tout_reg))
    else $error("output did not toggle on match");
  cmp_wrap_a: assert property (state_reg == ST_RUN && is_cmp && tick
    && cnt_reg == 16'hffff && !evt && !do_write |=> cnt_reg == 16'h0000)
    else $error("count did not wrap to zero");
  tick_only_a: assert property (!tick && !do_write |=>
    $stable(cnt_reg))
    else $error("count moved without timer tick");
  gate_hold_a: assert property (is_gated && !gate_act && !do_write
    |=> $stable(cnt_reg))
    else $error("gated count moved while inactive");
  gate_event_a: assert property (state_reg == ST_RUN && is_gated
    && gate_fall && ctrl_reg.icfg != ICFG_RELOAD |=> sts_reg[STS_GATE])
    else $error("gate release gave no event");
  gate_reload_a: assert property ((s_end_quiet and is_gated) |=>
    cnt_reg == 16'h0001 && state_reg == ST_RUN)
    else $error("gated reload did not restart");
  write_answer_a: assert property (do_write |=> bvalid_reg ##0
    !s_axi_awready)
    else $error("write not answered next cycle");
endmodule

// *** smt_pin_model.sv ***
// Far-side model of the timer input and output pins
`timescale 1ns/1ns
module smt_pin_model (
  input wire logic mclk,
  input wire logic level,
  input wire logic timer_out,
  input wire logic timer_out_en,
  output logic timer_in,
  output logic [7:0] toggles
);
  logic last_out; // Output level at the previous edge
  initial begin
    timer_in = 1'b0;
    toggles = 8'h00;
    last_out = 1'b0;
  end
  // Input moves just after an edge, as a synchronous source would
  always @(posedge mclk) begin
    timer_in <= level;
    // Only a driven pin counts; an undriven one tells nothing
    if (timer_out_en === 1'b1 && timer_out !== last_out) begin
      toggles <= toggles + 8'h01;
    end
    last_out <= timer_out;
  end
endmodule

// *** smt_timer_bench.sv ***
// Register-level testbench of the 16-bit mode timer
`timescale 1ns/1ns
module smt_timer_bench;
  import smt_pkg::*;
  logic mclk = 1'b0;
  logic rst;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, timer_in, timer_out;
  logic timer_out_en, irq, pin_level;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [7:0] toggles, t;
  logic [31:0] d;
  int failures, total_checks, cycles;
  time t0;
  // Reset table: offsets and expected contents
  logic [4:0] offs [5] = '{OFF_CTRL, OFF_COUNT, OFF_RELOAD, OFF_STATUS,
    OFF_MASK};
  logic [31:0] rstv [5] = '{{22'h0, CTRL_RST}, {16'h0, COUNT_RST},
    {16'h0, RELOAD_RST}, {29'h0, STS_RST}, {29'h0, STS_RST}};

  always #2 mclk = ~mclk;

  smt_timer smt_timer_i (.mclk(mclk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_in(timer_in),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .irq(irq));

  smt_pin_model smt_pin_model_i (.mclk(mclk), .level(pin_level),
    .timer_out(timer_out), .timer_out_en(timer_out_en),
    .timer_in(timer_in), .toggles(toggles));

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Address and data go out together; each drops once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp,
      input string what);
    logic [31:0] v;
    rd(a, v);
    check(what, v, exp);
  endtask

  // Control word with enable set
  function automatic logic [31:0] cw(input logic oe, input logic [1:0] ic,
      input logic [2:0] ps, input logic [1:0] md, input logic pl);
    return {22'h0, oe, ic, ps, md, pl, 1'b1};
  endfunction

  // Disable first, load everything, enable last
  task automatic setup(input logic [31:0] c, input logic [15:0] cnt,
      input logic [15:0] rl, input logic [2:0] m);
    wr(OFF_CTRL, c & 32'hfffffffe);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_COUNT, {16'h0, cnt});
    wr(OFF_RELOAD, {16'h0, rl});
    wr(OFF_MASK, {29'h0, m});
    wr(OFF_CTRL, c);
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    pin_level = 1'b0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (offs[i]) rchk(offs[i], rstv[i], "reset value");
    rchk(5'h14, 32'h0, "unmapped read data");
    check("unmapped read resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(5'h14, 32'h1);
    check("unmapped write resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    // One-shot at divide by 2: five ticks take ten cycles
    setup(cw(1'b1, 2'h0, 3'h1, MODE_ONESHOT, 1'b0), 16'h1, 16'h5, 3'h1);
    t0 = $time;
    wr(OFF_CTRL, cw(1'b1, 2'h0, 3'h1, MODE_ONESHOT, 1'b1));
    wait_irq();
    check("one-shot time", {31'h0, ($time - t0) / 4 inside {[6:12]}}, 1);
    rd(OFF_CTRL, d);
    check("enable after end", {31'h0, d[0]}, 32'h0);
    rchk(OFF_COUNT, 32'h1, "count after end");
    rchk(OFF_STATUS, 32'h1, "end event");
    check("output level", {31'h0, timer_out}, 32'h1);
    wr(OFF_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Triggered run for both edge polarities
    for (int p = 1; p >= 0; p--) begin
      pin_level <= ~p[0];
      setup(cw(1'b0, 2'h0, 3'h0, MODE_TRIG, p[0]), 16'h1, 16'h4, 3'h1);
      repeat (20) @(posedge mclk);
      rchk(OFF_STATUS, 32'h0, "idle status");
      rchk(OFF_COUNT, 32'h1, "idle count");
      pin_level <= p[0];
      wait_irq();
      check("trigger irq", {31'h0, irq}, 32'h1);
      rchk(OFF_COUNT, 32'h1, "count after trigger run");
    end
    // Compare across the wrap, with the pin wiggling
    setup(cw(1'b1, 2'h0, 3'h0, MODE_COMPARE, 1'b0), 16'hfffe, 16'h2, 3'h0);
    // Idle output follows polarity during setup; count only match toggles
    t = toggles;
    repeat (6) begin
      pin_level <= ~pin_level;
      @(posedge mclk);
    end
    rchk(OFF_STATUS, 32'h2, "compare status");
    rd(OFF_COUNT, d);
    check("count goes on", {31'h0, d[15:0] > 16'h2}, 32'h1);
    check("output toggles", {24'h0, toggles - t}, 32'h1);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    // Gated: closed gate holds, open gate counts, closing reports
    pin_level <= 1'b0;
    setup(cw(1'b0, ICFG_GATE, 3'h0, MODE_GATED, 1'b1), 16'h1, 16'hffff, 3'h4);
    repeat (10) @(posedge mclk);
    rchk(OFF_COUNT, 32'h1, "closed gate count");
    pin_level <= 1'b1;
    repeat (20) @(posedge mclk);
    pin_level <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(OFF_COUNT, d);
    check("gated count", {31'h0, d[15:0] > 16'h10}, 32'h1);
    rchk(OFF_STATUS, 32'h4, "gate event");
    check("gate irq", {31'h0, irq}, 32'h1);
    setup(cw(1'b0, ICFG_RELOAD, 3'h0, MODE_GATED, 1'b1), 16'h1, 16'h3, 3'h1);
    pin_level <= 1'b1;
    repeat (30) @(posedge mclk);
    rd(OFF_COUNT, d);
    check("gated reload range", {31'h0, d[15:0] inside {[1:3]}}, 1);
    pin_level <= 1'b0;
    repeat (5) @(posedge mclk);
    rchk(OFF_STATUS, 32'h1, "reload only");
    summarize();
  end
endmodule
